// ---- design/ccf_pkg.sv ----
// Purpose: shared constants and types of the condition flag block
// Assumes: one core clock, flags register reached over a plain port
// Notes: flag positions, register offsets and op codes live here only
package ccf_pkg;

	// flag positions inside condition_flags
	localparam int FLAG_V = 7;
	localparam int FLAG_H = 4;
	localparam int FLAG_I = 3;
	localparam int FLAG_N = 2;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 0;

	// widths
	localparam int DATA_W = 8;
	localparam int WORD_W = 16;
	localparam int REG_AW = 2;

	// reset value and implemented bits of condition_flags
	localparam logic [7:0] FLAGS_RST = 8'h08;
	localparam logic [7:0] FLAGS_IMPL = 8'h9F;

	// register offsets
	localparam logic [1:0] REG_FLAGS = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;

	// status register fields
	localparam int STAT_INHIBIT = 0;
	localparam int STAT_BLOCKED = 1;

	// decimal adjust constants
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [3:0] BCD_CORR = 4'h6;

	////////////////////////////////////////////////////////////////////
	typedef enum logic [4:0] {
		OP_NONE,
		OP_ADD,
		OP_ADC,
		OP_SUB,
		OP_SBC,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_DAA,
		OP_LOAD8,
		OP_LOAD16,
		OP_SHIFT,
		OP_BITTEST,
		OP_CLEAR_MASK,
		OP_SET_MASK,
		OP_TAP,
		OP_BRANCH
	} ccf_kind_t;

	typedef enum logic [1:0] {
		COND_GT,
		COND_GE,
		COND_LE,
		COND_LT
	} ccf_cond_t;

	typedef struct packed {
		ccf_kind_t kind;
		ccf_cond_t cond;
		logic [DATA_W-1:0] a;
		logic [DATA_W-1:0] b;
		logic [WORD_W-1:0] word;
		logic bit_out;
	} ccf_op_t;

	typedef struct packed {
		logic [DATA_W-1:0] val;
		logic [DATA_W-1:0] mask;
	} ccf_upd_t;

	typedef struct packed {
		logic res_valid;
		logic [DATA_W-1:0] res;
		logic br_valid;
		logic br_take;
	} ccf_res_t;

endpackage

// ---- design/ccf_alu.sv ----
// Purpose: byte arithmetic, logic and decimal adjust with flag results
// Assumes: purely combinational, driven by the flag block
// Notes: upd.mask marks the flags an operation defines
`timescale 1ns/1ns
`default_nettype none
module ccf_alu (
	// operation in
	input wire ccf_pkg::ccf_kind_t kind,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic c_in,
	input wire logic h_in,
	// result out
	output logic [7:0] res,
	output ccf_pkg::ccf_upd_t upd
);

	function automatic logic nib_over(input logic [3:0] nib);
		nib_over = nib > ccf_pkg::BCD_MAX;
	endfunction

	////////////////////////////////////////////////////////////////////
	// adder shared by add and subtract
	wire logic is_sub = (kind == ccf_pkg::OP_SUB) ||
		(kind == ccf_pkg::OP_SBC);
	wire logic is_add = (kind == ccf_pkg::OP_ADD) ||
		(kind == ccf_pkg::OP_ADC);
	wire logic use_c = (kind == ccf_pkg::OP_ADC) ||
		(kind == ccf_pkg::OP_SBC);
	wire logic c_used = use_c & c_in;
	wire logic cin = is_sub ? ~c_used : c_used;
	wire logic [7:0] b_eff = is_sub ? ~b : b;
	wire logic [8:0] sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};
	wire logic [4:0] low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} +
		{4'h0, cin};
	wire logic is_logic = (kind == ccf_pkg::OP_AND) ||
		(kind == ccf_pkg::OP_OR) || (kind == ccf_pkg::OP_XOR);
	wire logic is_daa = kind == ccf_pkg::OP_DAA;

	////////////////////////////////////////////////////////////////////
	// decimal adjust correction
	wire logic lo_adj = h_in | nib_over(a[3:0]);
	wire logic hi_adj = c_in | nib_over(a[7:4]) |
		((a[7:4] == ccf_pkg::BCD_MAX) & nib_over(a[3:0]));
	wire logic [7:0] corr = {hi_adj ? ccf_pkg::BCD_CORR : 4'h0,
		lo_adj ? ccf_pkg::BCD_CORR : 4'h0};

	assign res = (kind == ccf_pkg::OP_AND) ? (a & b) :
		(kind == ccf_pkg::OP_OR) ? (a | b) :
		(kind == ccf_pkg::OP_XOR) ? (a ^ b) :
		is_daa ? (a + corr) : sum[7:0];

	////////////////////////////////////////////////////////////////////
	// flag values and which flags the operation defines
	always_comb begin
		upd = '0;
		upd.val[ccf_pkg::FLAG_N] = res[7]; // see RULE_08
		upd.mask[ccf_pkg::FLAG_N] = 1'b1;
		upd.val[ccf_pkg::FLAG_Z] = res == 8'h00; // see RULE_10
		upd.mask[ccf_pkg::FLAG_Z] = 1'b1;
		if (is_add || is_sub) begin
			// see RULE_01
			upd.val[ccf_pkg::FLAG_V] = (a[7] == b_eff[7]) &&
				(sum[7] != a[7]);
			upd.mask[ccf_pkg::FLAG_V] = 1'b1;
			// see RULE_12
			upd.val[ccf_pkg::FLAG_C] = is_sub ? ~sum[8] : sum[8];
			upd.mask[ccf_pkg::FLAG_C] = 1'b1;
		end
		if (is_add) begin
			upd.val[ccf_pkg::FLAG_H] = low[4]; // see RULE_03
			upd.mask[ccf_pkg::FLAG_H] = 1'b1;
		end
		if (is_logic) begin
			upd.mask[ccf_pkg::FLAG_V] = 1'b1;
		end
		if (is_daa) begin
			upd.val[ccf_pkg::FLAG_C] = c_in | hi_adj; // see RULE_04
			upd.mask[ccf_pkg::FLAG_C] = 1'b1;
		end
	end

endmodule
`default_nettype wire

// ---- design/ccf_flags.sv ----
// Purpose: condition flag register, branch decision and interrupt mask
// Assumes: one op per cycle at most; ce low freezes all state
// Notes: data outputs are registered, irq_accept is combinational
//
// Functional notes
// RULE_01 - overflow flag bit 7 follows two's complement overflow of op
// RULE_02 - signed branches decide using overflow together with negative
// RULE_03 - add and add-with-carry set half-carry from bit 3 carry
// RULE_04 - decimal adjust uses half-carry and carry to correct to BCD
// RULE_05 - mask bit 3 set blocks maskable interrupts, clear allows them
// RULE_06 - taking an interrupt sets mask after the stack push completes
// RULE_07 - no interrupt at the boundary right after mask is cleared
// RULE_08 - negative flag bit 2 copies bit 7 of a result
// RULE_09 - loads and stores copy value msb into negative flag
// RULE_10 - zero flag bit 1 set when result is all zero
// RULE_11 - loads and stores set zero flag when value is all zero
// RULE_12 - carry bit 0 is add carry-out or subtract borrow
// RULE_13 - bit test, shift and rotate load carry from tested bit
// RULE_14 - flags an operation does not define keep their value
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
module ccf_flags #(
	parameter logic [7:0] RESET_FLAGS = ccf_pkg::FLAGS_RST
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// register port
	input wire logic [ccf_pkg::REG_AW-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// operation in
	input wire ccf_pkg::ccf_op_t op,
	// results out
	output ccf_pkg::ccf_res_t res,
	output logic [7:0] condition_flags,
	// interrupt sequencing
	input wire logic insn_boundary,
	input wire logic irq_pending,
	input wire logic stack_done,
	output logic irq_accept
);

	////////////////////////////////////////////////////////////////////
	// decode helpers
	function automatic logic is_alu(input ccf_pkg::ccf_kind_t k);
		case (k)
			ccf_pkg::OP_ADD, ccf_pkg::OP_ADC, ccf_pkg::OP_SUB,
			ccf_pkg::OP_SBC, ccf_pkg::OP_AND, ccf_pkg::OP_OR,
			ccf_pkg::OP_XOR, ccf_pkg::OP_DAA: is_alu = 1'b1;
			default: is_alu = 1'b0;
		endcase
	endfunction

	function automatic logic br_decide(input ccf_pkg::ccf_cond_t c,
		input logic [7:0] f);
		logic lt;
		lt = f[ccf_pkg::FLAG_N] ^ f[ccf_pkg::FLAG_V];
		case (c)
			ccf_pkg::COND_GT: br_decide = !(lt | f[ccf_pkg::FLAG_Z]);
			ccf_pkg::COND_GE: br_decide = !lt;
			ccf_pkg::COND_LE: br_decide = lt | f[ccf_pkg::FLAG_Z];
			ccf_pkg::COND_LT: br_decide = lt;
			default: br_decide = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// state
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic inhibit_q;
	logic inhibit_d;
	logic [7:0] rdata_q;
	ccf_pkg::ccf_res_t res_q;

	////////////////////////////////////////////////////////////////////
	// arithmetic unit
	logic [7:0] alu_res;
	ccf_pkg::ccf_upd_t alu_upd;

	ccf_alu u_alu (
		.kind(op.kind),
		.a(op.a),
		.b(op.b),
		.c_in(flags_q[ccf_pkg::FLAG_C]),
		.h_in(flags_q[ccf_pkg::FLAG_H]),
		.res(alu_res),
		.upd(alu_upd)
	);

	////////////////////////////////////////////////////////////////////
	// flag update from non-arithmetic ops
	ccf_pkg::ccf_upd_t loc_upd;
	wire logic [7:0] load_lo = op.word[7:0];
	wire logic load_w = op.kind == ccf_pkg::OP_LOAD16;
	wire logic load_msb = load_w ? op.word[15] : load_lo[7];
	wire logic load_zero = load_w ? (op.word == 16'h0000) :
		(load_lo == 8'h00);

	always_comb begin
		loc_upd = '0;
		case (op.kind)
			ccf_pkg::OP_LOAD8, ccf_pkg::OP_LOAD16: begin
				loc_upd.val[ccf_pkg::FLAG_N] = load_msb; // see RULE_09
				loc_upd.val[ccf_pkg::FLAG_Z] = load_zero; // see RULE_11
				loc_upd.mask[ccf_pkg::FLAG_N] = 1'b1;
				loc_upd.mask[ccf_pkg::FLAG_Z] = 1'b1;
			end
			ccf_pkg::OP_SHIFT: begin
				loc_upd.val[ccf_pkg::FLAG_C] = op.bit_out; // see RULE_13
				loc_upd.val[ccf_pkg::FLAG_N] = op.a[7];
				loc_upd.val[ccf_pkg::FLAG_Z] = op.a == 8'h00;
				loc_upd.val[ccf_pkg::FLAG_V] = op.a[7] ^ op.bit_out;
				loc_upd.mask[ccf_pkg::FLAG_C] = 1'b1;
				loc_upd.mask[ccf_pkg::FLAG_N] = 1'b1;
				loc_upd.mask[ccf_pkg::FLAG_Z] = 1'b1;
				loc_upd.mask[ccf_pkg::FLAG_V] = 1'b1;
			end
			ccf_pkg::OP_BITTEST: begin
				loc_upd.val[ccf_pkg::FLAG_C] = op.bit_out; // see RULE_13
				loc_upd.mask[ccf_pkg::FLAG_C] = 1'b1;
			end
			ccf_pkg::OP_CLEAR_MASK: begin
				loc_upd.mask[ccf_pkg::FLAG_I] = 1'b1;
			end
			ccf_pkg::OP_SET_MASK: begin
				loc_upd.val[ccf_pkg::FLAG_I] = 1'b1;
				loc_upd.mask[ccf_pkg::FLAG_I] = 1'b1;
			end
			ccf_pkg::OP_TAP: begin
				loc_upd.val = op.a;
				loc_upd.mask = ccf_pkg::FLAGS_IMPL;
			end
			default: begin
				loc_upd = '0;
			end
		endcase
	end

	wire ccf_pkg::ccf_upd_t upd = is_alu(op.kind) ? alu_upd : loc_upd;
	wire logic bus_flags_wr = reg_wr && (reg_addr == ccf_pkg::REG_FLAGS);

	////////////////////////////////////////////////////////////////////
	// per-bit next value: stack push set wins, then bus, then op
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			wire logic force_set = (gi == ccf_pkg::FLAG_I) && stack_done;
			assign flags_d[gi] = !ccf_pkg::FLAGS_IMPL[gi] ? 1'b0 :
				force_set ? 1'b1 : // see RULE_06
				bus_flags_wr ? reg_wdata[gi] :
				upd.mask[gi] ? upd.val[gi] :
				flags_q[gi]; // see RULE_14
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// interrupt shadow after the mask is cleared
	wire logic mask_cleared = flags_q[ccf_pkg::FLAG_I] &&
		!flags_d[ccf_pkg::FLAG_I];
	assign inhibit_d = mask_cleared ? 1'b1 : // see RULE_07
		insn_boundary ? 1'b0 : inhibit_q;
	wire logic blocked = flags_q[ccf_pkg::FLAG_I] || inhibit_q;
	// see RULE_05
	assign irq_accept = ce && insn_boundary && irq_pending && !blocked;

	////////////////////////////////////////////////////////////////////
	// registered results
	ccf_pkg::ccf_res_t res_d;
	always_comb begin
		res_d = '0;
		res_d.res_valid = is_alu(op.kind);
		res_d.res = alu_res;
		res_d.br_valid = op.kind == ccf_pkg::OP_BRANCH;
		// see RULE_02
		res_d.br_take = res_d.br_valid && br_decide(op.cond, flags_q);
	end

	wire logic [7:0] status_val = {6'h00, blocked, inhibit_q};
	wire logic [7:0] rdata_d = !reg_rd ? 8'h00 :
		(reg_addr == ccf_pkg::REG_FLAGS) ? flags_q :
		(reg_addr == ccf_pkg::REG_STATUS) ? status_val : 8'h00;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_q <= RESET_FLAGS;
			inhibit_q <= 1'b0;
			rdata_q <= 8'h00;
			res_q <= '0;
		end else if (ce) begin
			flags_q <= flags_d;
			inhibit_q <= inhibit_d;
			rdata_q <= rdata_d;
			res_q <= res_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign res = res_q;
	assign condition_flags = flags_q;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	wire logic chk_quiet = ce && !bus_flags_wr && !stack_done;
	wire logic [7:0] chk_sum = op.a + op.b;
	wire logic chk_ovf = (op.a[7] == op.b[7]) && (chk_sum[7] != op.a[7]);
	wire logic [4:0] chk_low = {1'b0, op.a[3:0]} + {1'b0, op.b[3:0]};
	wire logic chk_bcd_ok = (op.a[7:4] <= ccf_pkg::BCD_MAX) &&
		(op.a[3:0] <= ccf_pkg::BCD_MAX) &&
		!flags_q[ccf_pkg::FLAG_H] && !flags_q[ccf_pkg::FLAG_C];
	wire logic chk_ge = flags_q[ccf_pkg::FLAG_N] == flags_q[ccf_pkg::FLAG_V];

	chk_ovf_add: assert property ( // see RULE_01
		chk_quiet && op.kind == ccf_pkg::OP_ADD |=>
		condition_flags[ccf_pkg::FLAG_V] == $past(chk_ovf))
		else $error("overflow flag wrong after add");

	chk_branch_ge: assert property ( // see RULE_02
		ce && op.kind == ccf_pkg::OP_BRANCH &&
		op.cond == ccf_pkg::COND_GE |=>
		res.br_valid && res.br_take == $past(chk_ge))
		else $error("signed branch decision wrong");

	chk_half_carry: assert property ( // see RULE_03
		chk_quiet && op.kind == ccf_pkg::OP_ADD |=>
		condition_flags[ccf_pkg::FLAG_H] == $past(chk_low[4]))
		else $error("half carry wrong after add");

	chk_daa_valid: assert property ( // see RULE_04
		ce && op.kind == ccf_pkg::OP_DAA && chk_bcd_ok |=>
		res.res_valid && res.res == $past(op.a))
		else $error("decimal adjust altered valid bcd");

	chk_mask_blocks: assert property ( // see RULE_05
		condition_flags[ccf_pkg::FLAG_I] |-> !irq_accept)
		else $error("interrupt accepted while masked");

	chk_mask_stack: assert property ( // see RULE_06
		ce && stack_done |=> condition_flags[ccf_pkg::FLAG_I])
		else $error("mask not set after stack push");

	chk_cli_shadow: assert property ( // see RULE_07
		chk_quiet && condition_flags[ccf_pkg::FLAG_I] &&
		op.kind == ccf_pkg::OP_CLEAR_MASK |=>
		!irq_accept && inhibit_q)
		else $error("interrupt taken right after mask clear");

	chk_load_flags: assert property ( // see RULE_09
		chk_quiet && op.kind == ccf_pkg::OP_LOAD16 |=>
		condition_flags[ccf_pkg::FLAG_N] == $past(op.word[15]) &&
		condition_flags[ccf_pkg::FLAG_Z] == ($past(op.word) == 16'h0000))
		else $error("load flags wrong");

	chk_carry_sub: assert property ( // see RULE_12
		chk_quiet && op.kind == ccf_pkg::OP_SUB |=>
		condition_flags[ccf_pkg::FLAG_C] == ($past(op.a) < $past(op.b)))
		else $error("borrow flag wrong after subtract");

	chk_keep_flags: assert property ( // see RULE_14
		chk_quiet && op.kind == ccf_pkg::OP_BITTEST |=>
		condition_flags[7:1] == $past(condition_flags[7:1]) &&
		condition_flags[ccf_pkg::FLAG_C] == $past(op.bit_out))
		else $error("bit test changed other flags");

	chk_neg_and: assert property ( // see RULE_08
		chk_quiet && op.kind == ccf_pkg::OP_AND |=>
		condition_flags[ccf_pkg::FLAG_N] == $past(op.a[7] & op.b[7]))
		else $error("negative flag wrong after and");

	chk_zero_xor: assert property ( // see RULE_10
		chk_quiet && op.kind == ccf_pkg::OP_XOR |=>
		condition_flags[ccf_pkg::FLAG_Z] == ($past(op.a) == $past(op.b)))
		else $error("zero flag wrong after xor");

	chk_load_byte: assert property ( // see RULE_11
		chk_quiet && op.kind == ccf_pkg::OP_LOAD8 |=>
		condition_flags[ccf_pkg::FLAG_Z] == ($past(op.word[7:0]) == 8'h00))
		else $error("zero flag wrong after byte load");

	chk_shift_carry: assert property ( // see RULE_13
		chk_quiet && op.kind == ccf_pkg::OP_SHIFT |=>
		condition_flags[ccf_pkg::FLAG_C] == $past(op.bit_out))
		else $error("carry wrong after shift");

	chk_logic_ovf: assert property ( // see RULE_01
		chk_quiet && op.kind == ccf_pkg::OP_OR |=>
		!condition_flags[ccf_pkg::FLAG_V])
		else $error("overflow not cleared by logic op");

	cov_add_ovf: cover property (
		chk_quiet && op.kind == ccf_pkg::OP_ADD && chk_ovf);
	cov_irq_take: cover property (irq_accept ##[1:20] stack_done);
	cov_branch: cover property (res.br_valid && res.br_take);
	cov_daa_carry: cover property (
		ce && op.kind == ccf_pkg::OP_DAA && flags_q[ccf_pkg::FLAG_C]);

endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the condition flag block
// Assumes: flags register at index 0, status at index 1
// Notes: a reference model in the bench is compared every cycle outside reset
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	ccf_pkg::ccf_op_t op = '0;
	ccf_pkg::ccf_res_t res;
	logic [7:0] condition_flags;
	logic insn_boundary = 1'b0;
	logic irq_pending = 1'b0;
	logic stack_done = 1'b0;
	logic irq_accept;
	int fails = 0;
	int checked = 0;
	int want = -1;
	logic [31:0] seed = 32'h0000C1DF;
	logic [31:0] r;
	logic [31:0] q;
	logic [7:0] k;
	logic [7:0] mf;
	logic inh;
	ccf_pkg::ccf_res_t e_res;
	logic [7:0] e_rd;
	logic [7:0] e_rdm;

	ccf_flags #(.RESET_FLAGS(8'h08)) ccf_flags_inst (
		.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .op(op), .res(res),
		.condition_flags(condition_flags), .insn_boundary(insn_boundary),
		.irq_pending(irq_pending), .stack_done(stack_done),
		.irq_accept(irq_accept)
	);

	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// reference model, one step per rising edge
	task automatic tick();
		logic [8:0] s;
		logic [7:0] f;
		logic [7:0] a;
		logic [7:0] b;
		logic cin;
		logic hi;
		logic lo;
		logic nz;
		logic lt;
		@(posedge clk);
		a = op.a;
		b = op.b;
		f = mf;
		s = 9'h000;
		nz = 1'b1;
		lt = mf[2] ^ mf[7];
		if (sys_rst) begin
			mf = 8'h08;
			inh = 1'b0;
			e_res = '0;
			e_rd = 8'h00;
			e_rdm = 8'hFF;
		end else if (ce) begin
			e_res = '0;
			e_res.res = a + b;
			e_rdm = 8'hFF;
			e_rd = !reg_rd ? 8'h00 : (reg_addr == 2'h0) ? mf :
				(reg_addr == 2'h1) ? {6'h00, mf[3] | inh, inh} : 8'h00;
			case (op.kind)
				ccf_pkg::OP_ADD, ccf_pkg::OP_ADC: begin
					cin = (op.kind == ccf_pkg::OP_ADC) & mf[0];
					s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
					f[4] = ({1'b0, a[3:0]} + b[3:0] + cin) > 5'h0F;
					f[7] = (a[7] == b[7]) & (s[7] != a[7]);
					f[0] = s[8];
				end
				ccf_pkg::OP_SUB, ccf_pkg::OP_SBC: begin
					cin = (op.kind == ccf_pkg::OP_SBC) & mf[0];
					s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
					f[7] = (a[7] != b[7]) & (s[7] != a[7]);
					f[0] = s[8];
				end
				ccf_pkg::OP_AND: {s, f[7]} = {1'b0, a & b, 1'b0};
				ccf_pkg::OP_OR: {s, f[7]} = {1'b0, a | b, 1'b0};
				ccf_pkg::OP_XOR: {s, f[7]} = {1'b0, a ^ b, 1'b0};
				ccf_pkg::OP_DAA: begin
					lo = mf[4] | (a[3:0] > 4'h9);
					hi = mf[0] | (a > 8'h99);
					s = {1'b0, a} + {1'b0, hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
					f[0] = hi;
				end
				ccf_pkg::OP_LOAD8: s = {1'b0, op.word[7:0]};
				ccf_pkg::OP_LOAD16: begin
					nz = 1'b0;
					f[2] = op.word[15];
					f[1] = (op.word == 16'h0000);
				end
				ccf_pkg::OP_SHIFT: begin
					s = {1'b0, a};
					f[0] = op.bit_out;
					f[7] = a[7] ^ op.bit_out;
				end
				ccf_pkg::OP_BITTEST: {nz, f[0]} = {1'b0, op.bit_out};
				ccf_pkg::OP_CLEAR_MASK: {nz, f[3]} = 2'h0;
				ccf_pkg::OP_SET_MASK: {nz, f[3]} = 2'h1;
				ccf_pkg::OP_TAP: {nz, f} = {1'b0, a};
				ccf_pkg::OP_BRANCH: begin
					nz = 1'b0;
					e_res.br_valid = 1'b1;
					case (op.cond)
						ccf_pkg::COND_GT: e_res.br_take = !(lt | mf[1]);
						ccf_pkg::COND_GE: e_res.br_take = !lt;
						ccf_pkg::COND_LE: e_res.br_take = lt | mf[1];
						default: e_res.br_take = lt;
					endcase
				end
				default: nz = 1'b0;
			endcase
			if (nz) begin
				f[2] = s[7];
				f[1] = (s[7:0] == 8'h00);
			end
			if (op.kind >= ccf_pkg::OP_ADD && op.kind <= ccf_pkg::OP_DAA) begin
				e_res.res_valid = 1'b1;
				e_res.res = s[7:0];
			end
			if (reg_wr && reg_addr == 2'h0) begin
				f = reg_wdata;
			end
			if (stack_done) begin
				f[3] = 1'b1;
			end
			f = f & 8'h9F;
			if (mf[3] && !f[3]) begin
				inh = 1'b1;
			end else if (insn_boundary) begin
				inh = 1'b0;
			end
			mf = f;
		end
	endtask

	task automatic look();
		@(negedge clk);
		chk("flags_vh", {8'h00, mf & 8'h90}, {8'h00, condition_flags & 8'h90});
		chk("flags_nz", {8'h00, mf & 8'h06}, {8'h00, condition_flags & 8'h06});
		chk("flags_c", {8'h00, mf & 8'h01}, {8'h00, condition_flags & 8'h01});
		chk("flags_all", {8'h00, mf}, {8'h00, condition_flags});
		chk("res", {5'h00, e_res}, {5'h00, res});
		chk("reg_rdata", {8'h00, e_rd & e_rdm}, {8'h00, reg_rdata & e_rdm});
		chk("irq_accept", {15'h0000, ce & insn_boundary & irq_pending & !mf[3] & !inh}, {15'h0000, irq_accept});
		if (want >= 0) begin
			chk("irq_fixed", 16'(want), {15'h0000, irq_accept});
		end
	endtask

	// ctl is {write, read, boundary, stack done}
	task automatic step(ccf_pkg::ccf_kind_t kd, logic [7:0] a, logic [7:0] b,
		logic [3:0] ctl, logic [1:0] ad, logic [7:0] wd, int w);
		op <= '{kind: kd, cond: ccf_pkg::ccf_cond_t'(b[1:0]), a: a, b: b,
			word: {b, a}, bit_out: b[0]};
		{reg_wr, reg_rd, insn_boundary, stack_done} <= ctl;
		reg_addr <= ad;
		reg_wdata <= wd;
		want = w;
		look();
		tick();
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) tick();
		sys_rst <= 1'b0;
		irq_pending <= 1'b1;
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h4, 2'h0, 8'h00, -1);
		#1 chk("reset_flags", 16'h0008, {8'h00, condition_flags});
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h4, 2'h3, 8'h00, -1);
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h8, 2'h0, 8'hFF, -1);
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h8, 2'h2, 8'h00, -1);
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h8, 2'h0, 8'h00, -1);
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h4, 2'h1, 8'h00, -1);
		$display("test register port done");
		step(ccf_pkg::OP_SET_MASK, 8'h00, 8'h00, 4'h0, 2'h0, 8'h00, -1);
		step(ccf_pkg::OP_ADD, 8'h7F, 8'h01, 4'h0, 2'h0, 8'h00, -1);
		#1 chk("add_flags", 16'h009C, {8'h00, condition_flags});
		chk("add_res", 16'h0600, {5'h00, res});
		step(ccf_pkg::OP_ADD, 8'h15, 8'h27, 4'h0, 2'h0, 8'h00, -1);
		step(ccf_pkg::OP_DAA, 8'h3C, 8'h00, 4'h0, 2'h0, 8'h00, -1);
		#1 chk("daa_res", 16'h0508, {5'h00, res});
		for (int i = 0; i < 4; i++) begin
			step(ccf_pkg::OP_BRANCH, 8'h00, 8'(i), 4'h0, 2'h0, 8'h00, -1);
		end
		$display("test arithmetic and branch done");
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h2, 2'h0, 8'h00, 0);
		step(ccf_pkg::OP_CLEAR_MASK, 8'h00, 8'h00, 4'h0, 2'h0, 8'h00, -1);
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h2, 2'h0, 8'h00, 0);
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h2, 2'h0, 8'h00, 1);
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h1, 2'h0, 8'h00, -1);
		#1 chk("mask_set", 16'h0008, {8'h00, condition_flags & 8'h08});
		$display("test interrupt mask done");
		for (int n = 0; n < 2500; n++) begin
			r = xs();
			q = xs();
			k = (r[2:0] < 3'h4) ? q[7:0] % 8'h11 : 8'h00;
			ce <= (r[31:29] != 3'h0);
			irq_pending <= r[11];
			step(ccf_pkg::ccf_kind_t'(k[4:0]), q[15:8], q[23:16],
				{r[2:0] == 3'h4, r[2:0] != 3'h4 && r[8],
				r[2:1] == 2'h3 && r[12], r[2:0] == 3'h5},
				r[10:9], r[20:13], -1);
		end
		$display("test random traffic done");
		op <= '0;
		{reg_wr, reg_rd, insn_boundary, stack_done} <= 4'h0;
		ce <= 1'b1;
		sys_rst <= 1'b1;
		repeat (2) tick();
		sys_rst <= 1'b0;
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h4, 2'h1, 8'h00, -1);
		#1 chk("rst_flags", 16'h0008, {8'h00, condition_flags});
		step(ccf_pkg::OP_NONE, 8'h00, 8'h00, 4'h0, 2'h0, 8'h00, -1);
		$display("test mid-run reset done");
		tally_and_finish();
	end

	initial begin
		#2000000;
		fails = fails + 1;
		tally_and_finish();
	end
endmodule
`default_nettype wire
